// ---- hdl/page_port_decoder.sv ----
// Memory page decoder, port strobe decoder and wait state generator for the system bus.
`timescale 1ns/100ps
`default_nettype none
module page_port_decoder
   import page_port_pkg::*;
#(
   parameter bit INTA_BLOCK = 1'b1
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // System bus inputs from outside the clock domain.
   input wire bus_status_t bus_in,
   input wire logic [7:0] data_bus,
   // Memory selects.
   output page_sel_t page_sel,
   output logic mem_page_hit,
   output logic ram_we_n,
   // Wait state insertion.
   output logic ready,
   // Port strobes.
   output out_strobe_t out_strobes,
   output in_strobe_t in_strobes,
   output logic int_bus_sel,
   output mux_sel_t mux_sel,
   // Latched request-to-send line.
   output logic rts_out
);

   // Wait state machine states.
   typedef enum logic [1:0] {
      W_IDLE = 2'b00,
      W_HOLD = 2'b01,
      W_DONE = 2'b10
   } wait_state_t;

   // Two-stage synchronisers for bus status and data.
   bus_status_t bus_meta_reg;
   bus_status_t bus_reg;
   logic [7:0] data_meta_reg;
   logic [7:0] data_reg;
   // Previous sync value to find its rising edge.
   logic sync_prev_reg;

   // Decoded values before registering.
   page_sel_t page_next;
   logic hit_next;
   logic we_n_next;
   logic [7:0] out_dec;
   logic [7:0] in_dec;
   logic out_en;
   logic in_en;
   logic int_sel_next;
   mux_sel_t mux_next;
   logic block_inta;
   logic io_cycle;

   // Registered outputs.
   page_sel_t page_reg;
   logic hit_reg;
   logic we_n_reg;
   out_strobe_t out_reg;
   in_strobe_t in_reg;
   out_strobe_t out_next;
   in_strobe_t in_next;
   logic int_sel_reg;
   mux_sel_t mux_reg;
   logic rts_reg;
   logic rts_next;
   wait_state_t wait_reg;
   wait_state_t wait_next;
   logic ready_reg;
   logic ready_next;

   // Synchronise everything arriving from the bus before it is decoded.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bus_meta_reg <= BUS_IDLE; // Idle levels, so the overlay does not look active after reset.
         bus_reg <= BUS_IDLE;
         data_meta_reg <= 8'h00;
         data_reg <= 8'h00;
         sync_prev_reg <= 1'b0;
      end else begin
         bus_meta_reg <= bus_in;
         bus_reg <= bus_meta_reg;
         data_meta_reg <= data_bus;
         data_reg <= data_meta_reg;
         sync_prev_reg <= bus_reg.sync;
      end
   end

   // Page decode: high nibble C, or page zero during the overlay, and never in I/O cycles.
   always_comb begin
      block_inta = INTA_BLOCK && bus_reg.stat_inta;
      io_cycle = bus_reg.stat_inp || bus_reg.stat_out;
      page_next = 4'hF;
      if (!io_cycle && !block_inta) begin
         if (!bus_reg.boot_n) begin
            // Overlay blocks page C and maps page zero onto ROM C0.
            if (bus_reg.addr[15:10] == {BOOT_HIGH_NIBBLE, PAGE_SEL_ROM0}) begin
               page_next.rom0_n = 1'b0;
            end
         end else if (bus_reg.addr[15:12] == PAGE_HIGH_NIBBLE) begin
            case (bus_reg.addr[11:10])
               PAGE_SEL_ROM0: page_next.rom0_n = 1'b0;
               PAGE_SEL_ROM1: page_next.rom1_n = 1'b0;
               PAGE_SEL_RAM: page_next.ram_n = 1'b0;
               PAGE_SEL_DISP: page_next.disp_n = 1'b0;
               default: page_next = 4'hF;
            endcase
         end
      end
      hit_next = (page_next != 4'hF);
      // RAM write only on RAM page while memory write is asserted; ROM ignores it.
      we_n_next = !(!page_next.ram_n && bus_reg.mem_write);
   end

   // Port decode enables: bits 15..11 all ones, qualified by status and bus strobe.
   always_comb begin
      out_en = (bus_reg.addr[15:11] == PORT_HIGH_BITS) && !block_inta
         && bus_reg.stat_out && !bus_reg.write_n;
      in_en = (bus_reg.addr[15:11] == PORT_HIGH_BITS) && !block_inta
         && bus_reg.stat_inp && bus_reg.data_in;
   end

   // Output port decoder instance.
   port_strobe_decoder #(.WIDTH(8)) u_out_dec (
      .enable(out_en),
      .sel(bus_reg.addr[10:8]),
      .strobe(out_dec)
   );

   // Input port decoder instance.
   port_strobe_decoder #(.WIDTH(8)) u_in_dec (
      .enable(in_en),
      .sel(bus_reg.addr[10:8]),
      .strobe(in_dec)
   );

   // Map decoded lines onto named strobes, input mux and the RTS latch.
   always_comb begin
      out_next.scroll_load_strobe = out_dec[PORT_FE];
      out_next.par_out_strobe = out_dec[PORT_FD];
      out_next.tape_tx_load = out_dec[PORT_FB];
      out_next.ctrl_bits_strobe = out_dec[PORT_FA];
      out_next.serial_tx_load = out_dec[PORT_F9];
      out_next.rts_latch_strobe = out_dec[PORT_F8];
      in_next.switch_read_strobe = in_dec[PORT_FF];
      in_next.scroll_status_read = in_dec[PORT_FE];
      in_next.par_in_read = in_dec[PORT_FD];
      in_next.kbd_read = in_dec[PORT_FC];
      in_next.tape_rx_read = in_dec[PORT_FB];
      in_next.aux_status_read = in_dec[PORT_FA];
      in_next.serial_rx_read = in_dec[PORT_F9];
      in_next.serial_status_read = in_dec[PORT_F8];
      int_sel_next = |in_dec[PORT_FB:PORT_F8];
      // Display page overrides, then memory and internal ports, then keyboard and parallel.
      if (!page_next.disp_n) begin
         mux_next = MUX_BIDIR;
      end else if (hit_next || int_sel_next) begin
         mux_next = MUX_INT;
      end else if (in_dec[PORT_FC]) begin
         mux_next = MUX_KBD;
      end else if (in_dec[PORT_FD]) begin
         mux_next = MUX_PAR;
      end else begin
         mux_next = MUX_BIDIR;
      end
      rts_next = out_dec[PORT_F8] ? data_reg[4] : rts_reg;
   end

   // Wait state: ready drops on sync of a page or I/O cycle, releases one state later.
   always_comb begin
      wait_next = wait_reg;
      ready_next = ready_reg;
      case (wait_reg)
         W_IDLE: begin
            if (bus_reg.sync && !sync_prev_reg && (hit_next || io_cycle)) begin
               wait_next = W_HOLD;
               ready_next = 1'b0;
            end
         end
         W_HOLD: begin
            wait_next = W_DONE;
            ready_next = READY_RESET;
         end
         W_DONE: begin
            if (!bus_reg.sync) begin
               wait_next = W_IDLE;
            end
         end
         default: begin
            wait_next = W_IDLE;
            ready_next = READY_RESET;
         end
      endcase
   end

   // Register all outputs.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         page_reg <= 4'hF;
         hit_reg <= 1'b0;
         we_n_reg <= 1'b1;
         out_reg <= '0;
         in_reg <= '0;
         int_sel_reg <= 1'b0;
         mux_reg <= MUX_BIDIR;
         rts_reg <= 1'b0;
         wait_reg <= W_IDLE;
         ready_reg <= READY_RESET;
      end else begin
         page_reg <= page_next;
         hit_reg <= hit_next;
         we_n_reg <= we_n_next;
         out_reg <= out_next;
         in_reg <= in_next;
         int_sel_reg <= int_sel_next;
         mux_reg <= mux_next;
         rts_reg <= rts_next;
         wait_reg <= wait_next;
         ready_reg <= ready_next;
      end
   end

   // Output connections.
   assign page_sel = page_reg;
   assign mem_page_hit = hit_reg;
   assign ram_we_n = we_n_reg;
   assign ready = ready_reg;
   assign out_strobes = out_reg;
   assign in_strobes = in_reg;
   assign int_bus_sel = int_sel_reg;
   assign mux_sel = mux_reg;
   assign rts_out = rts_reg;

   // The wait lasts exactly one cycle.
   a_wait_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
      !ready |=> ready) else $error("ready held low more than one cycle");

   // Ready drops after a sync rising edge of a page or I/O cycle.
   a_wait_on_sync: assert property (@(posedge core_clk) disable iff (rst)
      (wait_reg == W_IDLE && bus_reg.sync && !sync_prev_reg && (hit_next || io_cycle)) |=> !ready)
      else $error("missing wait state");

   // No page select during I/O.
   a_no_page_io: assert property (@(posedge core_clk) disable iff (rst)
      $past(io_cycle) |-> page_sel == 4'hF) else $error("page selected in I/O cycle");

   // Hit follows the selects.
   a_hit_match: assert property (@(posedge core_clk) disable iff (rst)
      mem_page_hit == (page_sel != 4'hF)) else $error("page hit mismatch");

   // RAM write only on RAM page.
   a_ram_we_page: assert property (@(posedge core_clk) disable iff (rst)
      !ram_we_n |-> !page_sel.ram_n) else $error("RAM write outside RAM page");

   // Overlay blocks page C.
   a_boot_blocks_c: assert property (@(posedge core_clk) disable iff (rst)
      (!$past(bus_reg.boot_n) && $past(bus_reg.addr[15:12]) == PAGE_HIGH_NIBBLE) |-> page_sel == 4'hF)
      else $error("page C decoded during overlay");

   // Output strobes need write strobe.
   a_out_qualified: assert property (@(posedge core_clk) disable iff (rst)
      (out_strobes != '0) |-> ($past(bus_reg.stat_out) && !$past(bus_reg.write_n)))
      else $error("output strobe without write");

   // Internal bus select tracks F8 to FB reads.
   a_int_sel: assert property (@(posedge core_clk) disable iff (rst)
      int_bus_sel == (in_strobes.serial_status_read || in_strobes.serial_rx_read
         || in_strobes.aux_status_read || in_strobes.tape_rx_read))
      else $error("internal bus select mismatch");

   // Interrupt acknowledge blocks every page and port decode while the jumpers are fitted.
   a_inta_blocks: assert property (@(posedge core_clk) disable iff (rst)
      $past(block_inta) |-> (page_sel == 4'hF && out_strobes == '0 && in_strobes == '0))
      else $error("decode during interrupt acknowledge");

endmodule
`default_nettype wire

// ---- hdl/page_port_pkg.sv ----
// Package with address map constants, bus structs and selector codes for the page and port decoder.
package page_port_pkg;

   // Memory page decode.
   localparam logic [3:0] PAGE_HIGH_NIBBLE = 4'hC;    // Bits 15..12 of every on-board page.
   localparam logic [3:0] BOOT_HIGH_NIBBLE = 4'h0;    // Bits 15..12 of page zero during the overlay.
   localparam logic [1:0] PAGE_SEL_ROM0 = 2'h0;       // Bits 11..10 for ROM page C0.
   localparam logic [1:0] PAGE_SEL_ROM1 = 2'h1;       // Bits 11..10 for ROM page C4.
   localparam logic [1:0] PAGE_SEL_RAM = 2'h2;        // Bits 11..10 for system RAM page C8.
   localparam logic [1:0] PAGE_SEL_DISP = 2'h3;       // Bits 11..10 for display RAM page CC.

   // Port decode: bits 15..11 must all be one.
   localparam logic [4:0] PORT_HIGH_BITS = 5'h1F;
   localparam logic [2:0] PORT_F8 = 3'h0;             // Low three bits of port F8.
   localparam logic [2:0] PORT_F9 = 3'h1;
   localparam logic [2:0] PORT_FA = 3'h2;
   localparam logic [2:0] PORT_FB = 3'h3;
   localparam logic [2:0] PORT_FC = 3'h4;
   localparam logic [2:0] PORT_FD = 3'h5;
   localparam logic [2:0] PORT_FE = 3'h6;
   localparam logic [2:0] PORT_FF = 3'h7;

   // Reset values.
   localparam logic READY_RESET = 1'b1;               // Ready is high outside wait insertion.
   localparam logic [7:0] STROBE_RESET = 8'h00;       // All port strobes idle.

   // Input multiplexer selections.
   typedef enum logic [1:0] {
      MUX_KBD = 2'b00,
      MUX_PAR = 2'b01,
      MUX_INT = 2'b10,
      MUX_BIDIR = 2'b11
   } mux_sel_t;

   // Processor bus cycle status and strobes, sampled from the system bus.
   typedef struct packed {
      logic [15:0] addr;      // Address bus.
      logic sync;             // Start-of-cycle sync pulse.
      logic mem_write;        // Memory write strobe.
      logic data_in;          // Processor data-in strobe.
      logic write_n;          // Processor write strobe, active low.
      logic stat_inp;         // Input operation status.
      logic stat_out;         // Output operation status.
      logic stat_inta;        // Interrupt acknowledge status.
      logic boot_n;           // Start-up overlay, active low.
   } bus_status_t;

   // Idle bus level for the synchroniser reset: strobes off and overlay off, so no false decode follows reset.
   localparam bus_status_t BUS_IDLE = '{addr: 16'h0000, sync: 1'b0, mem_write: 1'b0, data_in: 1'b0,
      write_n: 1'b1, stat_inp: 1'b0, stat_out: 1'b0, stat_inta: 1'b0, boot_n: 1'b1};

   // Page selects, all active low.
   typedef struct packed {
      logic rom0_n;           // ROM page C0.
      logic rom1_n;           // ROM page C4.
      logic ram_n;            // System RAM page C8.
      logic disp_n;           // Display RAM page CC.
   } page_sel_t;

   // Output port strobes, active high.
   typedef struct packed {
      logic scroll_load_strobe;
      logic par_out_strobe;
      logic tape_tx_load;
      logic ctrl_bits_strobe;
      logic serial_tx_load;
      logic rts_latch_strobe;
   } out_strobe_t;

   // Input port strobes, active high.
   typedef struct packed {
      logic switch_read_strobe;
      logic scroll_status_read;
      logic par_in_read;
      logic kbd_read;
      logic tape_rx_read;
      logic aux_status_read;
      logic serial_rx_read;
      logic serial_status_read;
   } in_strobe_t;

endpackage

// ---- hdl/port_strobe_decoder.sv ----
// One-of-eight port strobe decoder with enable, shared by the input and output port decode.
`timescale 1ns/100ps
`default_nettype none
module port_strobe_decoder
   import page_port_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // Decode inputs.
   input wire logic enable,
   input wire logic [2:0] sel,
   // Decoded one-hot strobes.
   output logic [WIDTH-1:0] strobe
);

   // The select field covers exactly eight strobes, so any other width is refused at elaboration.
   if (WIDTH != 8) begin : g_width_check
      $error("port_strobe_decoder supports only eight strobes");
   end

   // One line is active only while the enable stands.
   always_comb begin
      strobe = STROBE_RESET;
      if (enable) begin
         strobe[sel] = 1'b1;
      end
   end

endmodule
`default_nettype wire

// ---- tb/cpu_bus_model.sv ----
// Processor bus model that runs memory and port cycles on the decoder's system bus.
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model
   import page_port_pkg::*;
(
   // Clock and wait line from the decoder.
   input wire logic core_clk,
   input wire logic ready,
   // Bus towards the decoder.
   output bus_status_t bus_in,
   output logic [7:0] data_bus
);
   // Idle bus: no status, write strobe off, overlay off.
   initial begin
      bus_in = '0;
      bus_in.write_n = 1'b1;
      bus_in.boot_n = 1'b1;
      data_bus = 8'h00;
   end

   // Opens a cycle (kind 0 read, 1 write, 2 input, 3 output, 4 output without write strobe),
   // pulses sync for one clock and counts the clocks in which ready holds the processor.
   task automatic start(input logic [15:0] addr, input int kind, input logic [7:0] data,
                        input logic boot_n, input logic inta, output int waits);
      bus_status_t b;
      b = '0;
      b.addr = addr;
      b.write_n = (kind != 3);
      b.mem_write = (kind == 1);
      b.data_in = (kind == 0) || (kind == 2);
      b.stat_inp = (kind == 2);
      b.stat_out = (kind >= 3);
      b.stat_inta = inta;
      b.boot_n = boot_n;
      b.sync = 1'b1;
      waits = 0;
      @(posedge core_clk);
      bus_in <= b;
      data_bus <= data;
      @(posedge core_clk);
      bus_in.sync <= 1'b0;
      repeat (6) begin
         @(posedge core_clk);
         #1;
         if (ready !== 1'b1) begin
            waits++;
         end
      end
   endtask

   // Ends the cycle; released address and data lines show the inverse of their last value.
   task automatic end_cycle();
      bus_status_t b;
      b = '0;
      b.write_n = 1'b1;
      b.boot_n = 1'b1;
      b.addr = ~bus_in.addr;
      @(posedge core_clk);
      bus_in <= b;
      data_bus <= ~data_bus;
      repeat (4) @(posedge core_clk);
      #1;
   endtask
endmodule
`default_nettype wire

// ---- tb/page_port_decoder_tb.sv ----
// Self-checking testbench for the page and port decoder.
`timescale 1ns/100ps
`default_nettype none
module page_port_decoder_tb;
   import page_port_pkg::*;
   logic core_clk;
   logic rst;
   bus_status_t bus_in;
   logic [7:0] data_bus;
   page_sel_t page_sel;
   logic mem_page_hit;
   logic ram_we_n;
   logic ready;
   out_strobe_t out_strobes;
   in_strobe_t in_strobes;
   logic int_bus_sel;
   mux_sel_t mux_sel;
   logic rts_out;
   int fail_count = 0;
   int checks = 0;
   int cycles = 0;
   int w;

   // Design under test with the interrupt jumpers fitted.
   page_port_decoder #(.INTA_BLOCK(1'b1)) page_port_decoder_inst (
      .core_clk(core_clk), .rst(rst), .bus_in(bus_in), .data_bus(data_bus),
      .page_sel(page_sel), .mem_page_hit(mem_page_hit), .ram_we_n(ram_we_n), .ready(ready),
      .out_strobes(out_strobes), .in_strobes(in_strobes), .int_bus_sel(int_bus_sel),
      .mux_sel(mux_sel), .rts_out(rts_out));

   // Processor on the far side of the bus.
   cpu_bus_model cpu_bus_model_inst (
      .core_clk(core_clk), .ready(ready), .bus_in(bus_in), .data_bus(data_bus));

   // 40 MHz clock.
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // Cuts a hung run short.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         $display("Timeout after %0d cycles", cycles);
         wrap_up();
      end
   end

   // Compares a seen value with the expected one.
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Every page, read at its low end and written at its high end; RAM alone takes the write enable.
   task automatic test_pages();
      for (int s = 0; s < 4; s++) begin
         for (int k = 0; k < 2; k++) begin
            cpu_bus_model_inst.start({PAGE_HIGH_NIBBLE, 2'(s), k ? 10'h3FF : 10'h000}, k, 8'h5A, 1'b1, 1'b0, w);
            check("page_sel", 8'(page_sel), 8'(4'hF & ~(4'h8 >> s)));
            check("hit", 8'(mem_page_hit), 8'h01);
            check("waits", 8'(w), 8'h01);
            check("ram_we_n", 8'(ram_we_n), 8'(!(k == 1 && s == 2)));
            check("mux", 8'(mux_sel), 8'(s == 3 ? MUX_BIDIR : MUX_INT));
            cpu_bus_model_inst.end_cycle();
            check("ram_we_n idle", 8'(ram_we_n), 8'h01);
         end
      end
      $display("test_pages done");
   endtask

   // Cycles that must not decode: off-page, I/O status, overlay, interrupt, bad port, no strobe.
   task automatic test_blocked();
      logic [15:0] ad [7] = '{16'hD000, 16'hC800, 16'hC800, 16'hC800, 16'hF800, 16'hE800, 16'hF800};
      int kd [7] = '{0, 2, 0, 0, 2, 3, 4};
      logic bt [7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
      logic it [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      int wx [7] = '{0, 1, 0, 0, 1, 1, 1};
      for (int i = 0; i < 7; i++) begin
         cpu_bus_model_inst.start(ad[i], kd[i], 8'hFF, bt[i], it[i], w);
         check("page_sel", 8'(page_sel), 8'h0F);
         check("hit", 8'(mem_page_hit), 8'h00);
         check("waits", 8'(w), 8'(wx[i]));
         check("in_strobes", 8'(in_strobes), 8'h00);
         check("out_strobes", 8'(out_strobes), 8'h00);
         cpu_bus_model_inst.end_cycle();
      end
      cpu_bus_model_inst.start(16'h0000, 0, 8'h00, 1'b0, 1'b0, w);
      check("boot page_sel", 8'(page_sel), 8'h07);
      check("boot waits", 8'(w), 8'h01);
      cpu_bus_model_inst.end_cycle();
      $display("test_blocked done");
   endtask

   // All eight port addresses read and written, six of them with an output strobe; strobes fall when the cycle ends.
   task automatic test_ports();
      logic [5:0] ox [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h00, 6'h10, 6'h20, 6'h00};
      for (int p = 0; p < 8; p++) begin
         cpu_bus_model_inst.start({PORT_HIGH_BITS, 3'(p), 8'h00}, 2, 8'h00, 1'b1, 1'b0, w);
         check("in_strobes", 8'(in_strobes), 8'h01 << p);
         check("int_bus_sel", 8'(int_bus_sel), 8'(p < 4));
         check("mux", 8'(mux_sel), 8'(p == 4 ? MUX_KBD : p == 5 ? MUX_PAR : p < 4 ? MUX_INT : MUX_BIDIR));
         check("waits in", 8'(w), 8'h01);
         check("out quiet", 8'(out_strobes), 8'h00);
         cpu_bus_model_inst.end_cycle();
         check("in idle", 8'(in_strobes), 8'h00);
         cpu_bus_model_inst.start({PORT_HIGH_BITS, 3'(p), 8'h00}, 3, 8'h00, 1'b1, 1'b0, w);
         check("out_strobes", 8'(out_strobes), 8'(ox[p]));
         check("in quiet", 8'(in_strobes), 8'h00);
         check("waits out", 8'(w), 8'h01);
         cpu_bus_model_inst.end_cycle();
         check("out idle", 8'(out_strobes), 8'h00);
      end
      $display("test_ports done");
   endtask

   // Request-to-send follows bit 4 on F8 only and holds between writes.
   task automatic test_rts();
      logic [2:0] pt [3] = '{PORT_F8, PORT_FA, PORT_F8};
      logic [7:0] dt [3] = '{8'h10, 8'hEF, 8'hEF};
      logic rx [3] = '{1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 3; i++) begin
         cpu_bus_model_inst.start({PORT_HIGH_BITS, pt[i], 8'h00}, 3, dt[i], 1'b1, 1'b0, w);
         cpu_bus_model_inst.end_cycle();
         check("rts_out", 8'(rts_out), 8'(rx[i]));
      end
      $display("test_rts done");
   endtask

   // A reset in mid-run clears the latch and leaves no false page select behind.
   task automatic test_reset();
      cpu_bus_model_inst.start({PORT_HIGH_BITS, PORT_F8, 8'h00}, 3, 8'h10, 1'b1, 1'b0, w);
      cpu_bus_model_inst.end_cycle();
      check("rts before reset", 8'(rts_out), 8'h01);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      check("rts after reset", 8'(rts_out), 8'h00);
      check("hit after reset", 8'(mem_page_hit), 8'h00);
      check("ready after reset", 8'(ready), 8'h01);
      cpu_bus_model_inst.start(16'hC800, 0, 8'h00, 1'b1, 1'b0, w);
      check("ram after reset", 8'(page_sel), 8'h0D);
      check("waits after reset", 8'(w), 8'h01);
      cpu_bus_model_inst.end_cycle();
      $display("test_reset done");
   endtask

   // Reset, then the scenarios.
   initial begin
      rst = 1'b1;
      repeat (7) @(posedge core_clk);
      #1;
      check("reset page_sel", 8'(page_sel), 8'h0F);
      check("reset ready", 8'(ready), 8'h01);
      check("reset out_strobes", 8'(out_strobes), 8'h00);
      check("reset in_strobes", 8'(in_strobes), 8'h00);
      check("reset rts_out", 8'(rts_out), 8'h00);
      check("reset ram_we_n", 8'(ram_we_n), 8'h01);
      @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      check("hit after release", 8'(mem_page_hit), 8'h00);
      @(posedge core_clk);
      test_pages();
      test_blocked();
      test_ports();
      test_rts();
      test_reset();
      wrap_up();
   end
endmodule
`default_nettype wire
